/* File: rtl/nv_access_pkg.sv */
// Purpose: shared constants for the byte-wide nonvolatile memory access block
// Assumes: 10 MHz system clock, separate 1 MHz calibrated oscillator for write timing
// Notes:   register indices are word indices; byte address is four times the index
//
// Overview of operation
// - strobe within four cycles of arming writes
// - strobe ignored while arm bit clear
// - arm bit self-clears four cycles later
// - no write while flash self-programming
// - strobe bit clears when programming ends
// - write start stalls cpu two cycles
// - read strobe loads data register two cycles later
// - read stalls cpu four cycles
// - busy write blocks reads, address changes
// - write lasts 8448 oscillator cycles
// - ready interrupt while enabled and idle
// - data register feeds writes, receives reads
// - address pair selects one of 4096 bytes
package nv_access_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned IDX_W    = 6;
  localparam int unsigned IRQ_W    = 2;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_CONTROL    = 6'h1C;
  localparam logic [IDX_W-1:0] IDX_DATA       = 6'h1D;
  localparam logic [IDX_W-1:0] IDX_ADDR_LO    = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_ADDR_HI    = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 6'h21;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTRL_READ_STROBE  = 0;
  localparam int unsigned CTRL_WRITE_STROBE = 1;
  localparam int unsigned CTRL_WRITE_ARM    = 2;
  localparam int unsigned CTRL_READY_IRQ_EN = 3;
  localparam int unsigned ADDR_HI_W         = 4;
  localparam int unsigned IRQ_WRITE_DONE    = 0;
  localparam int unsigned IRQ_READ_DONE     = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
  localparam logic [IRQ_W-1:0]  MASK_RESET = 2'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [2:0]  ARM_WINDOW_CYCLES  = 3'h4;
  localparam logic [2:0]  WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0]  READ_STALL_CYCLES  = 3'h4;
  localparam int unsigned CLOCK_PERIOD_NS    = 100;
  localparam int unsigned OSC_PERIOD_NS      = 1000;
  localparam int unsigned PROG_TIME_NS       = 8448000;
  localparam int unsigned PROG_TICKS         = PROG_TIME_NS / OSC_PERIOD_NS;

endpackage : nv_access_pkg

/* File: rtl/nv_memory.sv */
// Purpose: byte array holding the nonvolatile contents
// Assumes: one write port and one read port on the system clock
// Notes:   read data come out of a register one cycle after read_en
`timescale 1ns/1ps
`default_nettype none
module nv_memory #(
  parameter int unsigned ADDR_W = nv_access_pkg::ADDR_W,
  parameter int unsigned DATA_W = nv_access_pkg::DATA_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              write_en,
  input  wire logic [ADDR_W-1:0] write_addr,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic              read_en,
  input  wire logic [ADDR_W-1:0] read_addr,
  output logic      [DATA_W-1:0] read_data
);

  logic [DATA_W-1:0] cells [2**ADDR_W];
  logic [DATA_W-1:0] next_read_data;

  // a read of the cell being written returns the old byte
  always_comb begin
    next_read_data = read_en ? cells[read_addr] : read_data;
  end

  always_ff @(posedge clock) begin
    if (write_en) begin
      cells[write_addr] <= write_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_data <= '0;
    end else begin
      read_data <= next_read_data;
    end
  end

endmodule : nv_memory
`default_nettype wire

/* File: rtl/nv_access_control.sv */
// Purpose: software access to the nonvolatile byte array over classic Wishbone
// Assumes: osc_clock_in is the free-running 1 MHz calibrated oscillator, asynchronous
// Notes:   cpu_stall tells the core to hold its next instruction
`timescale 1ns/1ps
`default_nettype none
module nv_access_control #(
  parameter int unsigned prog_ticks = nv_access_pkg::PROG_TICKS
) (
  input  wire logic                                 clock,
  input  wire logic                                 rst,
  input  wire logic                                 cyc_i,
  input  wire logic                                 stb_i,
  input  wire logic                                 we_i,
  input  wire logic [nv_access_pkg::WB_ADR_W-1:0]   adr_i,
  input  wire logic [31:0]                          dat_i,
  input  wire logic [3:0]                           sel_i,
  output logic      [31:0]                          dat_o,
  output logic                                      ack_o,
  input  wire logic                                 osc_clock_in,
  input  wire logic                                 self_program_busy,
  input  wire logic                                 global_irq_enable,
  output logic                                      cpu_stall,
  output logic                                      ready_irq,
  output logic                                      irq
);

  localparam int unsigned TICK_W = $clog2(prog_ticks + 1);
  localparam logic [TICK_W-1:0] TICK_LOAD = TICK_W'(prog_ticks);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(1);

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic reg_hit(input logic [nv_access_pkg::WB_ADR_W-1:0] adr,
                                   input logic [nv_access_pkg::IDX_W-1:0]    idx);
    reg_hit = (adr[nv_access_pkg::WB_ADR_W-1:2] == idx);
  endfunction : reg_hit

  logic                               request;
  logic                               wr_lane0;
  logic                               arm_set;
  logic                               write_start;
  logic                               read_start;
  logic                               osc_tick;
  logic                               write_done;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [nv_access_pkg::ADDR_W-1:0]   nv_address;
  logic [nv_access_pkg::DATA_W-1:0]   nv_data;
  logic                               ready_irq_enable;
  logic                               write_arm;
  logic [2:0]                         arm_count;
  logic                               write_strobe;
  logic [TICK_W-1:0]                  tick_count;
  logic [nv_access_pkg::ADDR_W-1:0]   cap_addr;
  logic [nv_access_pkg::DATA_W-1:0]   cap_data;
  logic [2:0]                         stall_count;
  logic                               read_pending;
  logic [nv_access_pkg::IRQ_W-1:0]    irq_status;
  logic [nv_access_pkg::IRQ_W-1:0]    irq_mask;
  logic                               osc_sync1;
  logic                               osc_sync2;
  logic                               osc_sync3;
  logic [nv_access_pkg::DATA_W-1:0]   mem_rdata;

  logic [nv_access_pkg::ADDR_W-1:0]   next_nv_address;
  logic [nv_access_pkg::DATA_W-1:0]   next_nv_data;
  logic                               next_ready_irq_enable;
  logic                               next_write_arm;
  logic [2:0]                         next_arm_count;
  logic                               next_write_strobe;
  logic [TICK_W-1:0]                  next_tick_count;
  logic [nv_access_pkg::ADDR_W-1:0]   next_cap_addr;
  logic [nv_access_pkg::DATA_W-1:0]   next_cap_data;
  logic [2:0]                         next_stall_count;
  logic                               next_cpu_stall;
  logic                               next_read_pending;
  logic [nv_access_pkg::IRQ_W-1:0]    next_irq_status;
  logic [nv_access_pkg::IRQ_W-1:0]    next_irq_mask;
  logic                               next_ready_irq;
  logic                               next_irq;
  logic                               next_ack;
  logic [31:0]                        next_dat_o;
  logic [nv_access_pkg::DATA_W-1:0]   read_value;

  // ****************************************************************
  // strobes
  // ****************************************************************
  assign request  = cyc_i && stb_i && !ack_o;
  assign wr_lane0 = request && we_i && sel_i[0];
  assign arm_set  = wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_CONTROL)
                    && dat_i[nv_access_pkg::CTRL_WRITE_ARM];
  // arming and strobing in one access starts no write unless the arm bit is already set by an earlier arming write
  assign write_start = wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_CONTROL)
                       && dat_i[nv_access_pkg::CTRL_WRITE_STROBE]
                       && write_arm && !write_strobe && !self_program_busy;
  assign read_start  = wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_CONTROL)
                       && dat_i[nv_access_pkg::CTRL_READ_STROBE]
                       && !write_strobe && !write_start;
  // only the second and third stages feed the edge detector
  assign osc_tick   = osc_sync2 && !osc_sync3;
  assign write_done = write_strobe && osc_tick && (tick_count == TICK_LAST);

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb begin
    read_value = '0;
    case (adr_i[nv_access_pkg::WB_ADR_W-1:2])
      nv_access_pkg::IDX_CONTROL: begin
        // read strobe always reads zero
        read_value = {4'h0, ready_irq_enable, write_arm, write_strobe, 1'b0};
      end
      nv_access_pkg::IDX_DATA: begin
        read_value = nv_data;
      end
      nv_access_pkg::IDX_ADDR_LO: begin
        read_value = nv_address[7:0];
      end
      nv_access_pkg::IDX_ADDR_HI: begin
        read_value = {4'h0, nv_address[nv_access_pkg::ADDR_W-1:8]};
      end
      nv_access_pkg::IDX_IRQ_STATUS: begin
        read_value = {6'h00, irq_status};
      end
      nv_access_pkg::IDX_IRQ_MASK: begin
        read_value = {6'h00, irq_mask};
      end
      default: begin
        read_value = '0;
      end
    endcase

    next_ack   = request;
    next_dat_o = (request && !we_i) ? {24'h000000, read_value} : 32'h00000000;

    next_ready_irq_enable = ready_irq_enable;
    if (wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_CONTROL)) begin
      next_ready_irq_enable = dat_i[nv_access_pkg::CTRL_READY_IRQ_EN];
    end

    // arm window reloads on every arming write, then counts itself out
    if (arm_set) begin
      next_arm_count = nv_access_pkg::ARM_WINDOW_CYCLES;
    end else if (arm_count != 3'h0) begin
      next_arm_count = arm_count - 3'h1;
    end else begin
      next_arm_count = 3'h0;
    end
    next_write_arm = (next_arm_count != 3'h0);

    next_write_strobe = write_strobe;
    next_tick_count   = tick_count;
    next_cap_addr     = cap_addr;
    next_cap_data     = cap_data;
    if (write_start) begin
      next_write_strobe = 1'b1;
      next_tick_count   = TICK_LOAD;
      next_cap_addr     = nv_address;
      next_cap_data     = nv_data;
    end else if (write_done) begin
      next_write_strobe = 1'b0;
      next_tick_count   = '0;
    end else if (write_strobe && osc_tick) begin
      next_tick_count = tick_count - TICK_LAST;
    end

    next_nv_address = nv_address;
    if (wr_lane0 && !write_strobe) begin
      if (reg_hit(adr_i, nv_access_pkg::IDX_ADDR_LO)) begin
        next_nv_address[7:0] = dat_i[7:0];
      end
      if (reg_hit(adr_i, nv_access_pkg::IDX_ADDR_HI)) begin
        next_nv_address[nv_access_pkg::ADDR_W-1:8] = dat_i[nv_access_pkg::ADDR_HI_W-1:0];
      end
    end

    // fetched byte wins over a software write in the same cycle
    next_nv_data = nv_data;
    if (read_pending) begin
      next_nv_data = mem_rdata;
    end else if (wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_DATA)) begin
      next_nv_data = dat_i[7:0];
    end
    next_read_pending = read_start;

    if (write_start) begin
      next_stall_count = nv_access_pkg::WRITE_STALL_CYCLES;
    end else if (read_start) begin
      next_stall_count = nv_access_pkg::READ_STALL_CYCLES;
    end else if (stall_count != 3'h0) begin
      next_stall_count = stall_count - 3'h1;
    end else begin
      next_stall_count = 3'h0;
    end
    next_cpu_stall = (next_stall_count != 3'h0);

    next_irq_mask = irq_mask;
    if (wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_IRQ_MASK)) begin
      next_irq_mask = dat_i[nv_access_pkg::IRQ_W-1:0];
    end
    next_irq_status = irq_status;
    if (wr_lane0 && reg_hit(adr_i, nv_access_pkg::IDX_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~dat_i[nv_access_pkg::IRQ_W-1:0];
    end
    // a new event beats a clear in the same cycle
    next_irq_status[nv_access_pkg::IRQ_WRITE_DONE] = next_irq_status[nv_access_pkg::IRQ_WRITE_DONE] | write_done;
    next_irq_status[nv_access_pkg::IRQ_READ_DONE]  = next_irq_status[nv_access_pkg::IRQ_READ_DONE] | read_pending;
    next_irq = |(next_irq_status & next_irq_mask);

    next_ready_irq = next_ready_irq_enable && global_irq_enable && !next_write_strobe;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_o            <= 1'b0;
      dat_o            <= 32'h00000000;
      nv_address       <= nv_access_pkg::ADDR_RESET;
      nv_data          <= nv_access_pkg::DATA_RESET;
      ready_irq_enable <= 1'b0;
      write_arm        <= 1'b0;
      arm_count        <= 3'h0;
      write_strobe     <= 1'b0;
      tick_count       <= '0;
      cap_addr         <= nv_access_pkg::ADDR_RESET;
      cap_data         <= nv_access_pkg::DATA_RESET;
      stall_count      <= 3'h0;
      cpu_stall        <= 1'b0;
      read_pending     <= 1'b0;
      irq_status       <= '0;
      irq_mask         <= nv_access_pkg::MASK_RESET;
      ready_irq        <= 1'b0;
      irq              <= 1'b0;
      osc_sync1        <= 1'b0;
      osc_sync2        <= 1'b0;
      osc_sync3        <= 1'b0;
    end else begin
      ack_o            <= next_ack;
      dat_o            <= next_dat_o;
      nv_address       <= next_nv_address;
      nv_data          <= next_nv_data;
      ready_irq_enable <= next_ready_irq_enable;
      write_arm        <= next_write_arm;
      arm_count        <= next_arm_count;
      write_strobe     <= next_write_strobe;
      tick_count       <= next_tick_count;
      cap_addr         <= next_cap_addr;
      cap_data         <= next_cap_data;
      stall_count      <= next_stall_count;
      cpu_stall        <= next_cpu_stall;
      read_pending     <= next_read_pending;
      irq_status       <= next_irq_status;
      irq_mask         <= next_irq_mask;
      ready_irq        <= next_ready_irq;
      irq              <= next_irq;
      osc_sync1        <= osc_clock_in;
      osc_sync2        <= osc_sync1;
      osc_sync3        <= osc_sync2;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  // the cell is written at the end of the programming time from the captured copy
  nv_memory #(
    .ADDR_W (nv_access_pkg::ADDR_W),
    .DATA_W (nv_access_pkg::DATA_W)
  ) i_nv_memory (
    .clock      (clock),
    .rst        (rst),
    .write_en   (write_done),
    .write_addr (cap_addr),
    .write_data (cap_data),
    .read_en    (read_start),
    .read_addr  (nv_address),
    .read_data  (mem_rdata)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_ARM_HELD: assert property (@(posedge clock) disable iff (rst)
    arm_set |=> write_arm [*4]) else $error("arm bit did not stay set for four cycles");
  AST_ARM_TIMEOUT: assert property (@(posedge clock) disable iff (rst)
    arm_set ##1 (!arm_set) [*4] |=> !write_arm) else $error("arm bit did not time out");
  // checks the registered busy bit, not the start decode, so a broken decode is caught
  AST_START_NEEDS_ARM: assert property (@(posedge clock) disable iff (rst)
    $rose(write_strobe) |-> $past(write_arm) && !$past(self_program_busy))
    else $error("write started without arming");
  AST_UNARMED_IGNORED: assert property (@(posedge clock) disable iff (rst)
    !write_arm && !write_strobe |=> !write_strobe) else $error("strobe took effect while unarmed");
  AST_NO_START_SELF_PROG: assert property (@(posedge clock) disable iff (rst)
    self_program_busy && !write_strobe |=> !write_strobe) else $error("write started during self-programming");
  AST_STROBE_CLEARS: assert property (@(posedge clock) disable iff (rst)
    $fell(write_strobe) |-> $past(tick_count) == TICK_LAST && $past(osc_tick))
    else $error("strobe cleared before programming time elapsed");
  AST_WRITE_STALL: assert property (@(posedge clock) disable iff (rst)
    write_start |=> cpu_stall [*2] ##1 !cpu_stall) else $error("write stall is not two cycles");
  AST_READ_DATA: assert property (@(posedge clock) disable iff (rst)
    read_start ##1 1'b1 |=> nv_data == $past(mem_rdata)) else $error("read byte not in data register");
  AST_READ_STALL: assert property (@(posedge clock) disable iff (rst)
    read_start |=> cpu_stall [*4]) else $error("read stall shorter than four cycles");
  AST_BUSY_ADDR: assert property (@(posedge clock) disable iff (rst)
    write_strobe && !write_start |=> $stable(nv_address) && !read_pending)
    else $error("address changed or read done while busy");
  AST_TICK_LOAD: assert property (@(posedge clock) disable iff (rst)
    write_start |=> tick_count == TICK_LOAD && write_strobe) else $error("programming timer not loaded");
  // the global enable is a same-clock pin, seen one cycle late through the output flop
  AST_READY_IRQ: assert property (@(posedge clock) disable iff (rst)
    ready_irq == (ready_irq_enable && $past(global_irq_enable) && !write_strobe))
    else $error("ready interrupt does not follow enable and busy state");
  AST_CAPTURE: assert property (@(posedge clock) disable iff (rst)
    write_start |=> cap_addr == $past(nv_address) && cap_data == $past(nv_data))
    else $error("address or data not captured at write start");
  AST_READ_ONE_SHOT: assert property (@(posedge clock) disable iff (rst)
    ack_o && !we_i && reg_hit(adr_i, nv_access_pkg::IDX_CONTROL) |-> !dat_o[nv_access_pkg::CTRL_READ_STROBE])
    else $error("read strobe read back as one");
  AST_READ_PULSE: assert property (@(posedge clock) disable iff (rst)
    read_pending |=> !read_pending) else $error("read trigger stayed set");

endmodule : nv_access_control
`default_nettype wire

/* File: dv/eeprom_access_control_tb.sv */
// Purpose: self-checking bench for the nonvolatile access block over classic Wishbone
// Assumes: prog_ticks cut to 4, oscillator a slow square wave so the synchroniser sees each edge
// Notes:   memory starts unwritten, so only bytes written here are read back
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control_tb;
  localparam logic [5:0] ctl = nv_access_pkg::IDX_CONTROL;
  localparam logic [5:0] dat = nv_access_pkg::IDX_DATA;
  localparam logic [5:0] alo = nv_access_pkg::IDX_ADDR_LO;
  localparam logic [5:0] ahi = nv_access_pkg::IDX_ADDR_HI;
  localparam logic [5:0] sts = nv_access_pkg::IDX_IRQ_STATUS;
  localparam logic [5:0] msk = nv_access_pkg::IDX_IRQ_MASK;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        osc = 1'b0;
  logic        spm_busy = 1'b0;
  logic        gie = 1'b1;
  logic        cpu_stall;
  logic        ready_irq;
  logic        irq;
  logic [7:0]  q;
  int          n_fail = 0;
  int          compares = 0;
  int          stalls = 0;

  always #50 clock = ~clock;
  // slow square wave, changed on the rising edge like every other input
  always begin
    repeat (4) @(posedge clock);
    osc <= ~osc;
  end
  always @(posedge clock) if (cpu_stall === 1'b1) stalls = stalls + 1;

  nv_access_control #(.prog_ticks(4)) i_nv_access_control (
    .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o), .osc_clock_in(osc), .self_program_busy(spm_busy),
    .global_irq_enable(gie), .cpu_stall(cpu_stall), .ready_irq(ready_irq), .irq(irq));

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request held until ack is sampled; released at that edge only
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] r);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    sel <= 4'hF;
    @(posedge clock);
    while (ack_o !== 1'b1) @(posedge clock);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, i, d, r);
  endtask : wr

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00, q);
    chk(q, e);
  endtask : rd

  task automatic summarize;
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(ctl, 8'h00);
    rd(dat, 8'h00);
    rd(msk, 8'h00);
    rd(6'h30, 8'h00);
    wr(ctl, 8'h02);
    rd(ctl, 8'h00);
    wr(ctl, 8'h04);
    rd(ctl, 8'h04);
    rd(ctl, 8'h00);
    wr(ctl, 8'h04);
    rd(ctl, 8'h04);
    wr(ctl, 8'h02);
    rd(ctl, 8'h00);
    spm_busy <= 1'b1;
    wr(ctl, 8'h04);
    wr(ctl, 8'h02);
    rd(ctl, 8'h00);
    spm_busy <= 1'b0;
    wr(alo, 8'h34);
    wr(ahi, 8'h0A);
    rd(ahi, 8'h0A);
    wr(dat, 8'h5A);
    wr(ctl, 8'h0C);
    stalls = 0;
    wr(ctl, 8'h0A);
    rd(ctl, 8'h0A);
    chk({7'h0, ready_irq}, 8'h00);
    chk(stalls[7:0], 8'h02);
    wr(alo, 8'h11);
    rd(alo, 8'h34);
    wr(dat, 8'h77);
    wr(ctl, 8'h09);
    rd(dat, 8'h77);
    for (int k = 0; k < 100; k++) begin
      wb(1'b0, ctl, 8'h00, q);
      if (q[1] === 1'b0) break;
    end
    chk(q, 8'h08);
    chk({7'h0, ready_irq}, 8'h01);
    rd(sts, 8'h01);
    stalls = 0;
    wr(ctl, 8'h01);
    rd(dat, 8'h5A);
    rd(ctl, 8'h00);
    chk(stalls[7:0], 8'h04);
    rd(sts, 8'h03);
    chk({7'h0, irq}, 8'h00);
    wr(msk, 8'h02);
    rd(msk, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(sts, 8'h01);
    rd(sts, 8'h02);
    chk({7'h0, irq}, 8'h01);
    wr(sts, 8'h02);
    rd(sts, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(ctl, 8'h08);
    rd(ctl, 8'h08);
    chk({7'h0, ready_irq}, 8'h01);
    gie <= 1'b0;
    repeat (3) @(posedge clock);
    chk({7'h0, ready_irq}, 8'h00);
    summarize();
  end

  // ****************************************************************
  // watchdog: the sequence needs well under 2000 cycles
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule : eeprom_access_control_tb
`default_nettype wire
